// ---- rtl/tgu_cmp.v ----
// Purpose: Masked comparisons of a memory word and of the flag byte.
// Assumes: Byte mask bit i covers byte i of the word, bit 7 the top byte.
// Notes:   Purely combinational.
`timescale 1ns/10ps
`include "tgu_consts.vh"

module tgu_cmp
(
  // Memory word and operands
  input wire [63:0] mem_word,
  input wire [63:0] op_word,
  input wire [7:0] byte_mask,
  // Flag byte and operand
  input wire [7:0] flags,
  input wire [7:0] op_byte,
  // Results
  output wire word_eq,
  output wire word_gt,
  output wire word_lt,
  output wire flag_eq,
  output wire flag_ne
);

  function [63:0] tgu_expand;
    input [7:0] mask;
    integer i;
    begin
      tgu_expand = 64'h0000_0000_0000_0000;
      for (i = 0; i < 8; i = i + 1)
        tgu_expand[i*8 +: 8] = {8{mask[i]}};
    end
  endfunction

  wire [63:0] keep = tgu_expand(byte_mask);
  // Excluded bytes become zero on both sides, so they never decide order
  wire [63:0] m_val = mem_word & keep;
  wire [63:0] d_val = op_word & keep;

  assign word_eq = (m_val == d_val);
  assign word_gt = (m_val > d_val);
  assign word_lt = (m_val < d_val);
  assign flag_eq = (((flags ^ op_byte) & byte_mask) == 8'h00);
  assign flag_ne = (((flags ^ op_byte) & byte_mask) != 8'h00);

endmodule

// ---- rtl/tgu_consts.vh ----
// Purpose: Shared offsets, fields, reset values and command codes of the
//          group select/unselect command block.
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses below.
// Notes:   Definitions only.
`ifndef TGU_CONSTS_VH
`define TGU_CONSTS_VH

// Register byte offsets
`define TGU_OFS_CTRL 8'h00
`define TGU_OFS_CMD 8'h04
`define TGU_OFS_ADDR 8'h08
`define TGU_OFS_MASK 8'h0C
`define TGU_OFS_DATA_LO 8'h10
`define TGU_OFS_DATA_HI 8'h14
`define TGU_OFS_FLAGS 8'h18
`define TGU_OFS_STATUS 8'h1C
`define TGU_OFS_COUNT 8'h20
`define TGU_OFS_MEM_PTR 8'h24
`define TGU_OFS_MEM_DATA 8'h28

// Control register fields
`define TGU_CTRL_GO 0
`define TGU_CTRL_CRC_OK 1
`define TGU_CTRL_SET_READY 2
`define TGU_CTRL_SET_ID 3

// Status register fields
`define TGU_ST_ID 0
`define TGU_ST_REPLIED 1
`define TGU_ST_CRC_BAD 2
`define TGU_ST_BUSY 3
`define TGU_ST_SILENT 4

// Flag byte field: write-success flag
`define TGU_FLAG_WRITE_OK 1

// Reset values
`define TGU_FLAGS_RST 8'h00
`define TGU_COUNT_RST 8'h00

// Fetch lengths in bytes
`define TGU_WORD_BYTES 4'h8
`define TGU_BYTE_BYTES 4'h1

// Command codes
`define TGU_OP_UNSEL_MEM_EQ 8'h01
`define TGU_OP_UNSEL_MEM_NE 8'h02
`define TGU_OP_UNSEL_MEM_GT 8'h03
`define TGU_OP_UNSEL_MEM_LT 8'h04
`define TGU_OP_UNSEL_WRITE_OK 8'h05
`define TGU_OP_SEL_FLAGS_EQ 8'h06
`define TGU_OP_SEL_FLAGS_NE 8'h07
`define TGU_OP_UNSEL_FLAGS_EQ 8'h08
`define TGU_OP_UNSEL_FLAGS_NE 8'h09

// AXI responses
`define TGU_RESP_OKAY 2'h0
`define TGU_RESP_SLVERR 2'h2

`endif

// ---- rtl/tgu_mem.v ----
// Purpose: Byte-wide tag memory in flip-flops, one write and two read ports.
// Assumes: Address wraps modulo the depth.
// Notes:   Contents are data and have no reset value.
`timescale 1ns/10ps

module tgu_mem #(
  parameter DEPTH = 256,
  parameter AW = 8
)
(
  // Clock
  input wire aclk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  // Read ports
  input wire [AW-1:0] rd_addr_a,
  output wire [7:0] rd_data_a,
  input wire [AW-1:0] rd_addr_b,
  output wire [7:0] rd_data_b
);

  reg [7:0] mem_reg [0:DEPTH-1];

  always @(posedge aclk)
  begin
    if (wr_en)
      mem_reg[wr_addr] <= wr_data;
  end

  assign rd_data_a = mem_reg[rd_addr_a];
  assign rd_data_b = mem_reg[rd_addr_b];

endmodule

// ---- rtl/tgu_select_ctrl.v ----
// Purpose: Executes group unselect and flag select/unselect commands of a
//          passive tag and requests the identifier reply.
// Assumes: Command frames are decoded elsewhere and loaded over AXI4-Lite;
//          CRC result arrives with the go bit.
// Notes on behaviour
// - In identifying state, memory unselect fetches eight bytes at address, compares with word.
// - Memory unselect met: go to ready state, send nothing.
// - Not-equal variant is met when memory word differs from operand.
// - Greater variant is met when memory word exceeds operand.
// - Lower variant is met when memory word is below operand.
// - Memory unselect not met: clear counter, send identifier, stay identifying.
// - Write-success unselect in identifying state fetches one byte, compares with byte.
// - Byte matches and write flag set: silent to ready; else clear, reply.
// - Flag select in ready: pass clears counter, replies, enters identifying state.
// - Flag select in identifying state: clear counter, reply, stay, ignoring comparison.
// - All-zero mask makes equal-flags select pass for every tag.
// - Flag unselect in identifying state: pass goes to ready silently.
// - Flag unselect fails: clear counter, reply, stay identifying.
// - Every other state or case gives no reply.
// - Reply is preamble, unique identifier, then CRC.
// - Mask bit set includes its byte or flag bit; bit 7 is most significant.
// - Flag equal passes when all masked bits match operand.
// - Flag unequal passes when any masked bit differs.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "tgu_consts.vh"

module tgu_select_ctrl #(
  parameter MEM_BYTES = 256,
  parameter MEM_AW = 8,
  // Identifier value is arbitrary
  parameter [63:0] UID_VALUE = 64'h5A5A_0000_1234_0001
)
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Reply request towards the return-link framer
  output reg tx_start,
  output reg [63:0] tx_uid,
  output reg tag_in_id
);

  localparam ST_IDLE = 2'b00;
  localparam ST_FETCH = 2'b01;
  localparam ST_DECIDE = 2'b10;

  function [31:0] tgu_strb;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      tgu_strb = old_val;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          tgu_strb[i*8 +: 8] = new_val[i*8 +: 8];
    end
  endfunction

  // Bus-side holding registers
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  // Command operands and tag state
  reg [7:0] cmd_reg;
  reg [7:0] addr_reg;
  reg [7:0] mask_reg;
  reg [63:0] data_reg;
  reg [7:0] flags_reg;
  reg [7:0] count_reg;
  reg [MEM_AW-1:0] mem_ptr_reg;
  reg replied_reg;
  reg crc_bad_reg;
  reg silent_reg;

  // Execution
  reg [1:0] state_reg;
  reg [3:0] fetch_idx_reg;
  reg [3:0] fetch_len_reg;
  reg [63:0] word_reg;

  wire wr_commit = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire [31:0] wr_old;
  reg [31:0] wr_cur;
  reg wr_hit;
  reg [31:0] rd_val;
  reg rd_hit;

  wire [7:0] fetch_byte;
  wire [7:0] ptr_byte;
  wire [MEM_AW-1:0] fetch_addr = addr_reg[MEM_AW-1:0] + {{(MEM_AW-4){1'b0}}, fetch_idx_reg};
  wire mem_wr = wr_commit & (aw_addr_reg == `TGU_OFS_MEM_DATA) & w_strb_reg[0];

  wire word_eq;
  wire word_gt;
  wire word_lt;
  wire flag_eq;
  wire flag_ne;

  tgu_mem #(
    .DEPTH(MEM_BYTES),
    .AW(MEM_AW)
  ) u_mem (
    .aclk(aclk),
    .wr_en(mem_wr),
    .wr_addr(mem_ptr_reg),
    .wr_data(w_data_reg[7:0]),
    .rd_addr_a(fetch_addr),
    .rd_data_a(fetch_byte),
    .rd_addr_b(mem_ptr_reg),
    .rd_data_b(ptr_byte)
  );

  // Byte operand of flag commands is the last data byte, D0
  tgu_cmp u_cmp (
    .mem_word(word_reg),
    .op_word(data_reg),
    .byte_mask(mask_reg),
    .flags(flags_reg),
    .op_byte(data_reg[7:0]),
    .word_eq(word_eq),
    .word_gt(word_gt),
    .word_lt(word_lt),
    .flag_eq(flag_eq),
    .flag_ne(flag_ne)
  );

  // Write decode: current contents and whether the offset is mapped
  always @*
  begin
    wr_cur = 32'h0000_0000;
    wr_hit = 1'b1;
    case (aw_addr_reg)
      `TGU_OFS_CTRL: wr_cur = 32'h0000_0000;
      `TGU_OFS_CMD: wr_cur = {24'h00_0000, cmd_reg};
      `TGU_OFS_ADDR: wr_cur = {24'h00_0000, addr_reg};
      `TGU_OFS_MASK: wr_cur = {24'h00_0000, mask_reg};
      `TGU_OFS_DATA_LO: wr_cur = data_reg[31:0];
      `TGU_OFS_DATA_HI: wr_cur = data_reg[63:32];
      `TGU_OFS_FLAGS: wr_cur = {24'h00_0000, flags_reg};
      `TGU_OFS_STATUS: wr_cur = 32'h0000_0000;
      `TGU_OFS_COUNT: wr_cur = {24'h00_0000, count_reg};
      `TGU_OFS_MEM_PTR: wr_cur = 32'h0000_0000;
      `TGU_OFS_MEM_DATA: wr_cur = 32'h0000_0000;
      default: wr_hit = 1'b0;
    endcase
  end

  assign wr_old = tgu_strb(wr_cur, w_data_reg, w_strb_reg);

  // Read decode
  always @*
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TGU_OFS_CTRL: rd_val = 32'h0000_0000;
      `TGU_OFS_CMD: rd_val = {24'h00_0000, cmd_reg};
      `TGU_OFS_ADDR: rd_val = {24'h00_0000, addr_reg};
      `TGU_OFS_MASK: rd_val = {24'h00_0000, mask_reg};
      `TGU_OFS_DATA_LO: rd_val = data_reg[31:0];
      `TGU_OFS_DATA_HI: rd_val = data_reg[63:32];
      `TGU_OFS_FLAGS: rd_val = {24'h00_0000, flags_reg};
      `TGU_OFS_STATUS:
      begin
        rd_val[`TGU_ST_ID] = tag_in_id;
        rd_val[`TGU_ST_REPLIED] = replied_reg;
        rd_val[`TGU_ST_CRC_BAD] = crc_bad_reg;
        rd_val[`TGU_ST_BUSY] = (state_reg != ST_IDLE);
        rd_val[`TGU_ST_SILENT] = silent_reg;
      end
      `TGU_OFS_COUNT: rd_val = {24'h00_0000, count_reg};
      `TGU_OFS_MEM_PTR: rd_val[MEM_AW-1:0] = mem_ptr_reg;
      `TGU_OFS_MEM_DATA: rd_val = {24'h00_0000, ptr_byte};
      default: rd_hit = 1'b0;
    endcase
  end

  // AXI4-Lite handshakes; address and data may arrive in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TGU_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `TGU_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      else if (!aw_full_reg && !s_axi_bvalid && !wr_commit)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (!w_full_reg && !s_axi_bvalid && !wr_commit)
        s_axi_wready <= 1'b1;
      if (wr_commit)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `TGU_RESP_OKAY : `TGU_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `TGU_RESP_OKAY : `TGU_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  // Reply: counter cleared, framer told to send preamble, identifier, CRC
  task send_uid;
    begin
      count_reg <= 8'h00;
      tx_uid <= UID_VALUE;
      tx_start <= 1'b1;
      replied_reg <= 1'b1;
    end
  endtask

  // Register file and command execution; hardware updates come last so
  // that a flag set wins over a clear written in the same cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_reg <= 8'h00;
      addr_reg <= 8'h00;
      mask_reg <= 8'h00;
      data_reg <= 64'h0000_0000_0000_0000;
      flags_reg <= `TGU_FLAGS_RST;
      count_reg <= `TGU_COUNT_RST;
      mem_ptr_reg <= {MEM_AW{1'b0}};
      replied_reg <= 1'b0;
      crc_bad_reg <= 1'b0;
      silent_reg <= 1'b0;
      tag_in_id <= 1'b0;
      tx_start <= 1'b0;
      tx_uid <= 64'h0000_0000_0000_0000;
      state_reg <= ST_IDLE;
      fetch_idx_reg <= 4'h0;
      fetch_len_reg <= 4'h0;
      word_reg <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      tx_start <= 1'b0;
      if (wr_commit)
      begin
        case (aw_addr_reg)
          `TGU_OFS_CMD: cmd_reg <= wr_old[7:0];
          `TGU_OFS_ADDR: addr_reg <= wr_old[7:0];
          `TGU_OFS_MASK: mask_reg <= wr_old[7:0];
          `TGU_OFS_DATA_LO: data_reg[31:0] <= wr_old;
          `TGU_OFS_DATA_HI: data_reg[63:32] <= wr_old;
          `TGU_OFS_FLAGS: flags_reg <= wr_old[7:0];
          `TGU_OFS_COUNT: count_reg <= wr_old[7:0];
          `TGU_OFS_MEM_PTR: mem_ptr_reg <= wr_old[MEM_AW-1:0];
          `TGU_OFS_MEM_DATA:
            if (w_strb_reg[0])
              mem_ptr_reg <= mem_ptr_reg + {{(MEM_AW-1){1'b0}}, 1'b1};
          `TGU_OFS_STATUS:
            if (w_strb_reg[0])
            begin
              if (w_data_reg[`TGU_ST_REPLIED])
                replied_reg <= 1'b0;
              if (w_data_reg[`TGU_ST_CRC_BAD])
                crc_bad_reg <= 1'b0;
              if (w_data_reg[`TGU_ST_SILENT])
                silent_reg <= 1'b0;
            end
          `TGU_OFS_CTRL:
            if (w_strb_reg[0] && state_reg == ST_IDLE)
            begin
              if (w_data_reg[`TGU_CTRL_SET_READY])
                tag_in_id <= 1'b0;
              else if (w_data_reg[`TGU_CTRL_SET_ID])
                tag_in_id <= 1'b1;
            end
          default: ;
        endcase
      end
      case (state_reg)
        ST_IDLE:
          if (wr_commit && aw_addr_reg == `TGU_OFS_CTRL && w_strb_reg[0] &&
              w_data_reg[`TGU_CTRL_GO])
          begin
            fetch_idx_reg <= 4'h0;
            word_reg <= 64'h0000_0000_0000_0000;
            if (!w_data_reg[`TGU_CTRL_CRC_OK])
              crc_bad_reg <= 1'b1;
            else
            begin
              case (cmd_reg)
                `TGU_OP_UNSEL_MEM_EQ, `TGU_OP_UNSEL_MEM_NE,
                `TGU_OP_UNSEL_MEM_GT, `TGU_OP_UNSEL_MEM_LT:
                  if (tag_in_id)
                  begin
                    fetch_len_reg <= `TGU_WORD_BYTES;
                    state_reg <= ST_FETCH;
                  end
                `TGU_OP_UNSEL_WRITE_OK:
                  if (tag_in_id)
                  begin
                    fetch_len_reg <= `TGU_BYTE_BYTES;
                    state_reg <= ST_FETCH;
                  end
                `TGU_OP_SEL_FLAGS_EQ, `TGU_OP_SEL_FLAGS_NE:
                  if (tag_in_id)
                    send_uid;
                  else if ((cmd_reg == `TGU_OP_SEL_FLAGS_EQ) ? flag_eq : flag_ne)
                  begin
                    send_uid;
                    tag_in_id <= 1'b1;
                  end
                `TGU_OP_UNSEL_FLAGS_EQ, `TGU_OP_UNSEL_FLAGS_NE:
                  if (tag_in_id)
                  begin
                    if ((cmd_reg == `TGU_OP_UNSEL_FLAGS_EQ) ? flag_eq : flag_ne)
                    begin
                      tag_in_id <= 1'b0;
                      silent_reg <= 1'b1;
                    end
                    else
                      send_uid;
                  end
                default: ;
              endcase
            end
          end
        ST_FETCH:
        begin
          // In an eight-byte fetch the first byte lands in the top byte, matching operand order
          word_reg <= {word_reg[55:0], fetch_byte};
          fetch_idx_reg <= fetch_idx_reg + 4'h1;
          if (fetch_idx_reg == fetch_len_reg - 4'h1)
            state_reg <= ST_DECIDE;
        end
        ST_DECIDE:
        begin
          state_reg <= ST_IDLE;
          if ((cmd_reg == `TGU_OP_UNSEL_MEM_EQ && word_eq) ||
              (cmd_reg == `TGU_OP_UNSEL_MEM_NE && !word_eq) ||
              (cmd_reg == `TGU_OP_UNSEL_MEM_GT && word_gt) ||
              (cmd_reg == `TGU_OP_UNSEL_MEM_LT && word_lt) ||
              (cmd_reg == `TGU_OP_UNSEL_WRITE_OK && word_reg[7:0] == data_reg[7:0] &&
               flags_reg[`TGU_FLAG_WRITE_OK]))
          begin
            tag_in_id <= 1'b0;
            silent_reg <= 1'b1;
          end
          else
            send_uid;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// ---- sim/tgu_reader_model.sv ----
// Purpose: Reader-side model loading command frames over the register bus.
// Assumes: Tasks are called from one process at a time.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/10ps

module tgu_reader_model
(
  // Clock
  input wire aclk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready,
  // Wait limit ran out
  output logic hung
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
    s_axi_wstrb = 4'hF;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_p;
    logic w_p;
    logic done;
    @(posedge aclk);
    {n, aw_p, w_p, done, r} = {32'h0000_0000, 1'b1, 1'b1, 1'b0, 2'h3};
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 64)
    begin
      @(posedge aclk);
      n++;
      if (aw_p && s_axi_awready)
      begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_p && s_axi_wready)
      begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid)
      begin
        done = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!done)
      hung = 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    @(posedge aclk);
    {n, done, d, r} = {32'h0000_0000, 1'b0, 32'h0, 2'h3};
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 64)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid)
      begin
        done = 1'b1;
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
      end
    end
    if (!done)
      hung = 1'b1;
  endtask
endmodule

// ---- sim/tgu_select_ctrl_checker.sv ----
// Purpose: Port-level checks of the select/unselect command block.
// Assumes: Synchronous active-low reset, one clock.
// Notes:   Bound to every instance of the block.
`timescale 1ns/10ps

module tgu_select_ctrl_checker #(
  parameter [63:0] UID_VALUE = 64'h0000_0000_0000_0000
)
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Reply request
  input wire tx_start,
  input wire [63:0] tx_uid,
  input wire tag_in_id
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reply_one_cycle: assert property (tx_start |=> !tx_start)
    else $error("reply request longer than one cycle");
  a_reply_uid: assert property (tx_start |-> tx_uid == UID_VALUE)
    else $error("reply carries wrong identifier");
  // Every documented reply leaves the tag identifying
  a_reply_in_id: assert property (tx_start |-> tag_in_id)
    else $error("reply while not identifying");
  a_unselect_silent: assert property ($fell(tag_in_id) |-> !tx_start)
    else $error("reply on entering ready state");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !tx_start && !tag_in_id && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not on second edge");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_reopen: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
    else $error("write channels not reopened");
endmodule

bind tgu_select_ctrl tgu_select_ctrl_checker #(.UID_VALUE(UID_VALUE)) tgu_select_ctrl_checker_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .tx_start, .tx_uid, .tag_in_id);

// ---- sim/tgu_select_ctrl_tb.sv ----
// Purpose: Self-checking bench of the select/unselect command block.
// Assumes: Commands are loaded through the reader model's bus tasks.
// Notes:   A reference model predicts state, reply and counter per command.
`timescale 1ns/10ps
`include "tgu_consts.vh"

module tgu_select_ctrl_tb;
  localparam [63:0] UNIQUE_IDENTIFIER = 64'hC3A5_0F0F_7E81_2468; // Arbitrary identifier
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_start, tag_in_id, hung;
  wire [63:0] tx_uid;
  logic [7:0] mem_m [256];
  logic [7:0] m_flags, m_cnt;
  logic m_id;
  int errors, samples_checked, pulses;

  always #50 aclk = ~aclk;

  tgu_select_ctrl #(.UID_VALUE(UNIQUE_IDENTIFIER)) tgu_select_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_start, .tx_uid, .tag_in_id);

  tgu_reader_model tgu_reader_model_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hung);

  always @(posedge aclk)
    if (tx_start === 1'b1)
      pulses++;

  always @(posedge hung)
  begin
    errors++;
    conclude();
  end

  task automatic conclude();
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    tgu_reader_model_inst.wr(a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    tgu_reader_model_inst.rd(a, d, r);
  endtask

  // Reference model: word operand byte 7 is the top byte, mem[a] the top memory byte
  task automatic model_cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] m,
    input logic [63:0] dw, input logic crc, output logic reply);
    logic [63:0] mw, mk;
    logic feq, hit;
    reply = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      mw = {mw[55:0], mem_m[8'(a + k)]};
      mk[8*k +: 8] = {8{m[k]}};
    end
    feq = ((m_flags ^ dw[7:0]) & m) == 8'h00;
    case (op)
      8'h01: hit = (mw & mk) == (dw & mk);
      8'h02: hit = (mw & mk) != (dw & mk);
      8'h03: hit = (mw & mk) > (dw & mk);
      8'h04: hit = (mw & mk) < (dw & mk);
      8'h05: hit = mem_m[a] == dw[7:0] && m_flags[`TGU_FLAG_WRITE_OK];
      8'h06, 8'h08: hit = feq;
      default: hit = !feq;
    endcase
    if (!crc)
      return;
    if (op <= 8'h05 || op >= 8'h08)
    begin
      reply = m_id && !hit;
      m_id = m_id && !hit;
    end
    else if (m_id || hit)
    begin
      reply = 1'b1;
      m_id = 1'b1;
    end
    if (reply)
      m_cnt = 8'h00;
  endtask

  initial
  begin
    logic [7:0] op, a, m, fl;
    logic [63:0] dw;
    logic crc, reply, sil;
    logic [31:0] d;
    logic [1:0] r;
    int p0, n;
    {errors, samples_checked, pulses} = '0;
    void'($urandom(11));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TGU_OFS_STATUS, d, r);
    chk(64'(d), 64'h0);
    rd(`TGU_OFS_COUNT, d, r);
    chk(64'(d), 64'(`TGU_COUNT_RST));
    rd(8'h3C, d, r);
    chk(64'(r), 64'(`TGU_RESP_SLVERR));
    w(8'h40, 32'h0000_0001, r);
    chk(64'(r), 64'(`TGU_RESP_SLVERR));
    w(`TGU_OFS_MEM_PTR, 32'h0000_0000, r);
    for (int i = 0; i < 256; i++)
    begin
      mem_m[i] = 8'($urandom);
      w(`TGU_OFS_MEM_DATA, {24'h0, mem_m[i]}, r);
    end
    // Readback path of the memory window, at a random pointer
    a = 8'($urandom);
    w(`TGU_OFS_MEM_PTR, {24'h0, a}, r);
    rd(`TGU_OFS_MEM_DATA, d, r);
    chk(64'(d), 64'(mem_m[a]));
    for (int i = 0; i < 72; i++)
    begin
      op = 8'(1 + i % 9);
      a = 8'($urandom);
      m = (i % 5 == 0) ? 8'h00 : (i % 7 == 3) ? 8'hFF : 8'($urandom);
      fl = 8'($urandom);
      dw = {$urandom, $urandom};
      if ($urandom % 2)
      begin
        for (int k = 0; k < 8; k++)
          dw = {dw[55:0], mem_m[8'(a + k)]};
        if (op >= 8'h06)
          dw[7:0] = fl;
      end
      if (op == 8'h05 && ($urandom % 2))
        dw[7:0] = mem_m[a];
      crc = ($urandom % 8) != 0;
      m_flags = fl;
      m_cnt = 8'(1 + $urandom % 255);
      m_id = 1'((i / 9) % 2);
      w(`TGU_OFS_FLAGS, {24'h0, fl}, r);
      w(`TGU_OFS_COUNT, {24'h0, m_cnt}, r);
      w(`TGU_OFS_CTRL, m_id ? 32'h0000_0008 : 32'h0000_0004, r);
      w(`TGU_OFS_CMD, {24'h0, op}, r);
      w(`TGU_OFS_ADDR, {24'h0, a}, r);
      w(`TGU_OFS_MASK, {24'h0, m}, r);
      w(`TGU_OFS_DATA_LO, dw[31:0], r);
      w(`TGU_OFS_DATA_HI, dw[63:32], r);
      // Sticky status bits are cleared so each command is judged alone
      w(`TGU_OFS_STATUS, 32'h0000_0016, r);
      p0 = pulses;
      w(`TGU_OFS_CTRL, {30'h0, crc, 1'b1}, r);
      n = 0;
      d = 32'h0000_0008;
      while (d[`TGU_ST_BUSY] !== 1'b0 && n < 40)
      begin
        rd(`TGU_OFS_STATUS, d, r);
        n++;
      end
      if (d[`TGU_ST_BUSY] !== 1'b0)
      begin
        errors++;
        conclude();
      end
      model_cmd(op, a, m, dw, crc, reply);
      sil = ((i / 9) % 2 == 1) && !m_id;
      chk(64'(d), 64'({sil, 1'b0, !crc, reply, m_id}));
      chk(64'(tag_in_id), 64'(m_id));
      chk(64'(pulses - p0), 64'(reply));
      rd(`TGU_OFS_COUNT, d, r);
      chk(64'(d), 64'(m_cnt));
      if (reply)
        chk(tx_uid, UNIQUE_IDENTIFIER);
    end
    conclude();
  end
endmodule
